// file: rtl/css_top.sv
`timescale 1ns/1ps
`include "css_map.svh"
module css_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        cfg_clk,
  input  wire logic        cfg_din,
  output logic             cfg_dout,
  input  wire logic        program_request_n,
  input  wire logic        init_i,
  output logic             init_o,
  output logic             init_oe,
  input  wire logic        done_i,
  output logic             done_o,
  output logic             done_oe,
  input  wire logic [2:0]  mode_sel,
  input  wire logic [1:0]  startup_clock_select,
  input  wire logic        gts_wait_done,
  input  wire logic        gwe_wait_done,
  input  wire logic [2:0]  lock_wait_phase,
  input  wire logic        clock_manager_locked,
  input  wire logic        tap_clk,
  input  wire logic        user_step,
  input  wire logic        host_word_valid,
  input  wire logic [31:0] host_word,
  input  wire logic        user_gsr,
  input  wire logic        user_gts,
  input  wire logic        user_capture,
  input  wire logic [31:0] user_state,
  input  wire logic        rb_req,
  input  wire logic [4:0]  rb_addr,
  output logic             rb_valid,
  output logic [31:0]      rb_data,
  output logic             cfg_error,
  output logic             global_set_reset,
  output logic             global_output_tristate,
  output logic             global_write_enable
);

  // link domain (cfg_clk)
  logic [1:0]  lm_m_ff;
  logic [1:0]  lm_s_ff;
  logic [31:0] sr_ff;
  logic [4:0]  bcnt_ff;
  logic [31:0] lword_ff;
  logic        ltg_ff;
  logic        ctg_ff;
  logic        pbit_ff;
  logic [31:0] pcnt_ff;
  logic        dout_ff;
  logic [1:0]  lmode_ff;

  wire l_load = (lm_s_ff == `CSS_LM_LOAD);
  wire l_pass = (lm_s_ff == `CSS_LM_PASS);
  wire l_room = (pcnt_ff != `CSS_PASS_MAX);
  wire word_end = (bcnt_ff == `CSS_BIT_LAST);

  always_ff @(posedge cfg_clk or posedge rst) begin
    if (rst) begin
      lm_m_ff <= `CSS_LM_IDLE;
      lm_s_ff <= `CSS_LM_IDLE;
    end else begin
      lm_m_ff <= lmode_ff;
      lm_s_ff <= lm_m_ff;
    end
  end

  // serial data in on rising edge, one word per 32 bits
  always_ff @(posedge cfg_clk or posedge rst) begin
    if (rst) begin
      sr_ff    <= 32'h00000000;
      bcnt_ff  <= 5'h00;
      lword_ff <= 32'h00000000;
      ltg_ff   <= 1'b0;
    end else if (l_load) begin
      sr_ff   <= {sr_ff[30:0], cfg_din};
      bcnt_ff <= bcnt_ff + 5'h01;
      if (word_end) begin
        lword_ff <= {sr_ff[30:0], cfg_din};
        ltg_ff   <= ~ltg_ff;
      end
    end else begin
      bcnt_ff <= 5'h00;
    end
  end

  // each rising cfg_clk edge toggles so the core can step start-up on it
  always_ff @(posedge cfg_clk or posedge rst) begin
    if (rst) begin
      ctg_ff <= 1'b0;
    end else begin
      ctg_ff <= ~ctg_ff;
    end
  end

  always_ff @(posedge cfg_clk or posedge rst) begin
    if (rst) begin
      pbit_ff <= 1'b0;
      pcnt_ff <= 32'h00000000;
    end else if (l_pass && l_room) begin
      pbit_ff <= cfg_din;
      pcnt_ff <= pcnt_ff + 32'h00000001;
    end else if (!l_pass) begin
      pcnt_ff <= 32'h00000000;
    end
  end

  always_ff @(negedge cfg_clk or posedge rst) begin
    if (rst) begin
      dout_ff <= 1'b0;
    end else begin
      dout_ff <= l_pass & pbit_ff;
    end
  end

  assign cfg_dout = dout_ff;

  // core domain
  // synchronisers: prog, init, done, lock, tap_clk, word toggle, tick toggle, mode
  logic [9:0] s1_ff;
  logic [9:0] s2_ff;
  logic [2:0] d_ff;

  wire [9:0] s_in = {mode_sel, ctg_ff, ltg_ff, tap_clk, clock_manager_locked,
                     done_i, init_i, program_request_n};
  wire       prog_s = s2_ff[0];
  wire       init_s = s2_ff[1];
  wire       done_s = s2_ff[2];
  wire       lock_s = s2_ff[3];
  wire       tck_s  = s2_ff[4];
  wire       ltg_s  = s2_ff[5];
  wire       ctg_s  = s2_ff[6];
  wire [2:0] mode_s = s2_ff[9:7];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_ff <= 10'h000;
      s2_ff <= 10'h000;
      d_ff  <= 3'h0;
    end else if (clk_en) begin
      s1_ff <= s_in;
      s2_ff <= s1_ff;
      d_ff  <= {ctg_s, ltg_s, tck_s};
    end
  end

  wire tck_tick  = tck_s & ~d_ff[0];
  wire lw_edge   = ltg_s ^ d_ff[1];
  wire cclk_tick = ctg_s ^ d_ff[2];

  css_pkg::css_state_t state_ff;
  css_pkg::css_state_t nxt_state;
  logic [4:0]  wcnt_ff;
  logic [31:0] ck_ff;
  logic [2:0]  mode_ff;
  logic [2:0]  phase_ff;
  logic [3:0]  plo_ff;
  logic        init_oe_ff;
  logic        done_oe_ff;
  logic        od_low_ff;
  logic        gsr_ff;
  logic        gts_ff;
  logic        gwe_ff;
  logic        rb_valid_ff;
  logic [31:0] rb_data_ff;
  logic [31:0] cap_ff;
  logic        err_ff;
  logic [31:0] mem [0:15];

  wire prog_long = (plo_ff >= `CSS_PROG_CYC);
  wire prog_hold = ~prog_s & prog_long;
  wire in_clear  = (state_ff == css_pkg::st_clear);
  wire in_load   = (state_ff == css_pkg::st_load);
  wire in_start  = (state_ff == css_pkg::st_startup);
  wire in_user   = (state_ff == css_pkg::st_user);
  wire m_sser    = (mode_ff == `CSS_MODE_SSER);
  wire m_tap     = (mode_ff == `CSS_MODE_TAP);
  wire m_spar    = (mode_ff == `CSS_MODE_SPAR);

  // word source by sampled mode; the test port alone loads in mode 101
  wire ser_take  = in_load & m_sser & lw_edge;
  wire host_take = in_load & (m_tap | m_spar) & host_word_valid;
  wire take      = ser_take | host_take;
  wire [31:0] word_in = m_sser ? lword_ff : host_word;
  wire last_word = (wcnt_ff == `CSS_CFG_WORDS);
  wire ck_ok     = (ck_ff == word_in);

  // start-up stepping clock and pause conditions
  wire step_sel = (startup_clock_select == `CSS_SCLK_CCLK) ? cclk_tick :
                  (startup_clock_select == `CSS_SCLK_USER) ? user_step :
                  (startup_clock_select == `CSS_SCLK_TAP)  ? tck_tick  : 1'b0;
  wire hold_lock = (lock_wait_phase == phase_ff) & ~lock_s;
  wire hold_gts  = gts_wait_done & (phase_ff == (`CSS_GTS_PH - 3'h1)) & ~done_s;
  wire hold_gwe  = gwe_wait_done & (phase_ff == (`CSS_GWE_PH - 3'h1)) & ~done_s;
  wire step_go   = in_start & step_sel & ~hold_lock & ~hold_gts & ~hold_gwe
                   & (phase_ff != `CSS_GWE_PH);

  always_comb begin
    nxt_state = state_ff;
    if (prog_hold) begin
      nxt_state = css_pkg::st_clear;
    end else begin
      unique case (state_ff)
        css_pkg::st_clear: begin
          if (prog_s && wcnt_ff == `CSS_CLR_LAST) nxt_state = css_pkg::st_init_wait;
        end
        css_pkg::st_init_wait: begin
          if (init_s) nxt_state = css_pkg::st_load;
        end
        css_pkg::st_load: begin
          if (take && last_word) begin
            nxt_state = ck_ok ? css_pkg::st_startup : css_pkg::st_error;
          end
        end
        css_pkg::st_startup: begin
          if (phase_ff == `CSS_GWE_PH) nxt_state = css_pkg::st_user;
        end
        css_pkg::st_user:  nxt_state = css_pkg::st_user;
        css_pkg::st_error: nxt_state = css_pkg::st_error;
        default:           nxt_state = css_pkg::st_error;
      endcase
    end
  end

  wire chg = (nxt_state != state_ff);
  wire [4:0] nxt_wcnt = (chg || (in_clear && !prog_s)) ? 5'h00 :
                        ((in_clear && prog_s) || take) ? wcnt_ff + 5'h01 : wcnt_ff;
  wire [2:0] nxt_phase = (nxt_state != css_pkg::st_startup) ? 3'h0 :
                         step_go ? phase_ff + 3'h1 : phase_ff;
  wire nx_start = (nxt_state == css_pkg::st_startup);
  wire nx_user  = (nxt_state == css_pkg::st_user);
  wire nx_done  = nx_user | (nx_start & (nxt_phase >= `CSS_DONE_PH));
  wire nx_gts   = nx_user | (nx_start & (nxt_phase >= `CSS_GTS_PH));
  wire nx_gwe   = nx_user | (nx_start & (nxt_phase >= `CSS_GWE_PH));
  // link mode follows the mode being captured, so no stray load reaches the link
  wire [2:0] nxt_mode = (state_ff == css_pkg::st_init_wait && init_s) ? mode_s : mode_ff;
  wire [1:0] nxt_lmode = (nxt_mode != `CSS_MODE_SSER) ? `CSS_LM_IDLE :
                         (nxt_state == css_pkg::st_load) ? `CSS_LM_LOAD :
                         (nx_start | nx_user) ? `CSS_LM_PASS : `CSS_LM_IDLE;
  wire rb_ok = in_user & rb_req & (m_spar | m_tap) & ~prog_hold;
  wire [31:0] rb_word = rb_addr[4] ? cap_ff : mem[rb_addr[3:0]];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      plo_ff <= 4'h0;
    end else if (clk_en) begin
      if (prog_s) begin
        plo_ff <= 4'h0;
      end else if (!prog_long) begin
        plo_ff <= plo_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= css_pkg::st_clear;
      wcnt_ff  <= 5'h00;
      phase_ff <= 3'h0;
      mode_ff  <= 3'h0;
      ck_ff    <= 32'h00000000;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      wcnt_ff  <= nxt_wcnt;
      phase_ff <= nxt_phase;
      mode_ff  <= nxt_mode;
      if (chg) begin
        ck_ff <= 32'h00000000;
      end else if (take && !last_word) begin
        ck_ff <= ck_ff ^ word_in;
      end
    end
  end

  // memory is cleared word by word, so it needs no reset
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (in_clear && prog_s) begin
        mem[wcnt_ff[3:0]] <= 32'h00000000;
      end else if (take && !last_word) begin
        mem[wcnt_ff[3:0]] <= word_in;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_oe_ff <= 1'b1;
      done_oe_ff <= 1'b1;
      od_low_ff  <= 1'b0;
      err_ff     <= 1'b0;
      lmode_ff   <= `CSS_LM_IDLE;
    end else if (clk_en) begin
      init_oe_ff <= (nxt_state == css_pkg::st_clear) |
                    (nxt_state == css_pkg::st_error);
      done_oe_ff <= ~nx_done;
      od_low_ff  <= 1'b0;
      err_ff     <= (nxt_state == css_pkg::st_error);
      lmode_ff   <= nxt_lmode;
    end
  end

  // global controls: user may assert reset and three-state once running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gsr_ff <= 1'b1;
      gts_ff <= 1'b1;
      gwe_ff <= 1'b0;
    end else if (clk_en) begin
      gsr_ff <= nx_gwe ? (nx_user & user_gsr) : 1'b1;
      gts_ff <= ~nx_gts | (nx_user & user_gts);
      gwe_ff <= nx_gwe;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_ff      <= 32'h00000000;
      rb_valid_ff <= 1'b0;
      rb_data_ff  <= 32'h00000000;
    end else if (clk_en) begin
      if (user_capture) cap_ff <= user_state;
      rb_valid_ff <= rb_ok;
      if (rb_ok) rb_data_ff <= rb_word;
    end
  end

  assign init_o                 = od_low_ff;
  assign init_oe                = init_oe_ff;
  assign done_o                 = od_low_ff;
  assign done_oe                = done_oe_ff;
  assign rb_valid               = rb_valid_ff;
  assign rb_data                = rb_data_ff;
  assign cfg_error              = err_ff;
  assign global_set_reset       = gsr_ff;
  assign global_output_tristate = gts_ff;
  assign global_write_enable    = gwe_ff;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_init_clear_low: assert property (
    in_clear |-> init_oe_ff)
    else $error("init not driven low while clearing");

  a_gsr_held_cfg: assert property (
    (in_clear || in_load || state_ff == css_pkg::st_init_wait) |-> gsr_ff)
    else $error("global set/reset dropped during configuration");

  a_init_wait_hold: assert property (
    (clk_en && state_ff == css_pkg::st_init_wait && !init_s && !prog_hold)
      |=> state_ff == css_pkg::st_init_wait)
    else $error("sequencer left init wait while init low");

  a_prog_restart: assert property (
    (clk_en && prog_hold) |=> in_clear && init_oe_ff && done_oe_ff && !gwe_ff)
    else $error("long program request did not restart");

  a_done_end_only: assert property (
    !done_oe_ff |-> (in_start && phase_ff >= `CSS_DONE_PH) || in_user)
    else $error("done released before start-up phase");

  a_gts_after_done: assert property (
    ($fell(gts_ff) && in_start) |-> !done_oe_ff && $past(!done_oe_ff))
    else $error("three-state released without done a step earlier");

  a_gwe_after_gts: assert property (
    $rose(gwe_ff) |-> !gts_ff && $past(!gts_ff))
    else $error("write enable released before three-state release");

  a_rb_mode_only: assert property (
    rb_valid_ff |-> (m_spar || m_tap) && in_user)
    else $error("readback answered in a mode without readback");

  a_tap_no_serial: assert property (
    (in_load && m_tap) |-> lmode_ff == `CSS_LM_IDLE)
    else $error("serial link enabled in test-port mode");

  a_lock_pause: assert property (
    (clk_en && in_start && hold_lock && !prog_hold) |=> $stable(phase_ff))
    else $error("start-up advanced without clock manager lock");

endmodule

// file: rtl/css_map.svh
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// Notes on behaviour
// - once memory is full, forward serial data on the chain output at falling cclk.
// - mode 101 waits for loading through the test port; other modes disabled.
// - the four-wire test port stays usable whatever the mode pins say; here it loads and reads back only in modes 101 and 110.
// - serial pass-through supports 4,294,967,264 bits; test chains have no limit.
// - after reset or program request: clear memory, load data, then start up.
// - drive init low while clearing memory, release it when clearing completes.
// - while the init line is held low outside, the sequencer waits.
// - keep global set/reset asserted for the whole of configuration.
// - release the done output only when all of configuration has finished.
// - when a program request is released, clear memory and continue onward.
// - pulse global set/reset at the end so flip-flops start known.
// - release output three-state one start-up step after done goes high.
// - release write enable one start-up step after the three-state release.
// - three-state and write-enable release may wait for the shared done line.
// - start-up may pause at a chosen phase until clock managers lock.
// - start-up stepping clock selectable: cclk, user clock or test clock.
// - user logic can assert global set/reset and output three-state.
// - readback only in slave parallel and test-port modes.
// - readback returns configuration data and captured user state.
// - a capture strobe picks the moment user state is sampled for readback.
// - mode pins are sampled when init goes high after clearing.
// - a program request low 300 ns or more restarts configuration on release.
// - slave serial data is captured on the rising configuration clock edge.
`define CSS_MODE_SSER   3'h7
`define CSS_MODE_TAP    3'h5
`define CSS_MODE_SPAR   3'h6
`define CSS_CFG_WORDS   5'h10
`define CSS_CLR_LAST    5'h0F
`define CSS_BIT_LAST    5'h1F
`define CSS_PROG_MIN_NS 300
`define CSS_CLK_MHZ     20
`define CSS_PROG_CYC    4'((`CSS_PROG_MIN_NS * `CSS_CLK_MHZ + 999) / 1000)
`define CSS_PASS_MAX    32'hFFFFFFE0
`define CSS_DONE_PH     3'h4
`define CSS_GTS_PH      3'h5
`define CSS_GWE_PH      3'h6
`define CSS_LM_IDLE     2'h0
`define CSS_LM_LOAD     2'h1
`define CSS_LM_PASS     2'h3
`define CSS_SCLK_CCLK   2'h0
`define CSS_SCLK_USER   2'h1
`define CSS_SCLK_TAP    2'h2
`endif

// file: rtl/css_pkg.sv
package css_pkg;
  typedef enum logic [2:0] {
    st_clear,
    st_init_wait,
    st_load,
    st_startup,
    st_user,
    st_error
  } css_state_t;
endpackage

// file: bench/css_host_model.sv
`timescale 1ns/1ps
module css_host_model (
  input  wire logic init_oe,
  input  wire logic done_oe,
  input  wire logic cfg_dout,
  input  wire logic hold_init,
  input  wire logic hold_done,
  output logic      cfg_clk,
  output logic      cfg_din,
  output logic      init_pin,
  output logic      done_pin
);
  logic [31:0] echo_ff = 32'h0;

  // pulled-up open-drain lines, low while any party pulls them
  assign init_pin = ~(init_oe | hold_init);
  assign done_pin = ~(done_oe | hold_done);

  initial begin
    cfg_clk = 1'b0;
    cfg_din = 1'b0;
  end

  // msb first; the clock stands still between frames
  task automatic send_bits(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      cfg_din = w[i];
      #61.5 cfg_clk = 1'b1;
      #62.5 cfg_clk = 1'b0;
      #1 echo_ff = {echo_ff[30:0], cfg_dout};
    end
    // released data line must not keep showing the last bit
    cfg_din = ~cfg_din;
  endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clock = 1'b0, rst = 1'b1, clk_en = 1'b1, program_request_n = 1'b1;
  logic        cfg_clk, cfg_din, cfg_dout, init_pin, init_o, init_oe;
  logic        done_pin, done_o, done_oe, rb_valid, cfg_error;
  logic [2:0]  mode_sel = 3'h7, lock_wait_phase = 3'h0;
  logic [1:0]  startup_clock_select = 2'h1;
  logic        gts_wait_done = 1'b0, gwe_wait_done = 1'b0, clock_manager_locked = 1'b1;
  logic        tap_clk = 1'b0, user_step = 1'b0, host_word_valid = 1'b0, user_gsr = 1'b0;
  logic        user_gts = 1'b0, user_capture = 1'b0, rb_req = 1'b0, hold_init = 1'b0;
  logic        hold_done = 1'b0;
  logic        global_set_reset, global_output_tristate, global_write_enable;
  logic [31:0] host_word = 32'h0, user_state = 32'h0, rb_data;
  logic [4:0]  rb_addr = 5'h0;
  int          err_count = 0, samples_checked = 0;

  css_top dut (
    .clock, .rst, .clk_en, .cfg_clk, .cfg_din, .cfg_dout, .program_request_n,
    .init_i(init_pin), .init_o, .init_oe, .done_i(done_pin), .done_o, .done_oe,
    .mode_sel, .startup_clock_select, .gts_wait_done, .gwe_wait_done, .lock_wait_phase,
    .clock_manager_locked, .tap_clk, .user_step, .host_word_valid, .host_word,
    .user_gsr, .user_gts, .user_capture, .user_state, .rb_req, .rb_addr, .rb_valid,
    .rb_data, .cfg_error, .global_set_reset, .global_output_tristate, .global_write_enable
  );

  css_host_model host (
    .init_oe, .done_oe, .cfg_dout, .hold_init, .hold_done, .cfg_clk, .cfg_din,
    .init_pin, .done_pin
  );

  always #25 clock = ~clock;

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] wd(input int i);
    return 32'h5A5A0000 + 32'(i);
  endfunction

  task automatic tick;
    if (startup_clock_select == 2'h2) tap_clk = 1'b1;
    else user_step = 1'b1;
    step(1);
    tap_clk = 1'b0;
    user_step = 1'b0;
    step(3);
  endtask

  task automatic restart(input logic [2:0] m);
    mode_sel = m;
    program_request_n = 1'b0;
    step(10);
    chk("gts_prog", 1'b1, global_output_tristate);
    program_request_n = 1'b1;
    step(4);
    chk("init_clear", 1'b1, init_oe);
    for (int k = 0; k < 40 && init_oe !== 1'b0; k++) step(1);
    chk("init_free", 1'b0, init_oe);
    // bits sent while init is held low must be ignored
    hold_init = 1'b1;
    host.send_bits(32'hFFFFFFFF, 32);
    hold_init = 1'b0;
    step(6);
    host.send_bits(32'h0, 2);
    step(1);
  endtask

  task automatic load(input logic tap, input logic bad);
    logic [31:0] w;
    logic [31:0] x;
    x = 32'h0;
    for (int i = 0; i < 17; i++) begin
      w = (i < 16) ? wd(i) : x ^ {31'h0, bad};
      x = x ^ w;
      if (tap) begin
        host_word = w;
        host_word_valid = 1'b1;
        step(1);
        host_word_valid = 1'b0;
        step(1);
      end else begin
        host.send_bits(w, 32);
      end
    end
    step(8);
  endtask

  task automatic startup(input logic wdone);
    int nd = 0;
    int ng = 0;
    int nw = 0;
    gts_wait_done = wdone;
    hold_done = wdone;
    chk("done_cfg", 1'b1, done_oe);
    for (int i = 1; i <= 14; i++) begin
      if (i == 9) hold_done = 1'b0;
      tick();
      if (nd == 0 && done_oe === 1'b0) nd = i;
      if (ng == 0 && global_output_tristate === 1'b0) ng = i;
      if (nw == 0 && global_write_enable === 1'b1) nw = i;
      if (nw == 0) chk("gsr_cfg", 1'b1, global_set_reset);
    end
    if (wdone) chk("gts_wait", 1'b1, {31'h0, ng > 8});
    else chk("gts_step", nd + 1, ng);
    chk("gwe_step", ng + 1, nw);
    chk("gsr_end", 1'b0, global_set_reset);
    chk("done_pin", 1'b1, done_pin);
    gts_wait_done = 1'b0;
  endtask

  task automatic rb(input logic [4:0] a, input logic [31:0] e, input logic ok);
    rb_addr = a;
    rb_req = 1'b1;
    step(1);
    rb_req = 1'b0;
    chk("rb_valid", ok, rb_valid);
    if (ok) chk("rb_data", e, rb_data);
    step(1);
  endtask

  task automatic t_serial;
    restart(3'h7);
    load(1'b0, 1'b0);
    startup_clock_select = 2'h2;
    startup(1'b1);
    startup_clock_select = 2'h1;
    host.send_bits(32'h0, 2);
    host.send_bits(32'hC3A596E1, 32);
    step(1);
    chk("chain_out", 32'hC3A596E1, host.echo_ff);
    rb(5'h03, 32'h0, 1'b0);
  endtask

  task automatic t_crc;
    restart(3'h7);
    load(1'b0, 1'b1);
    chk("init_err", 1'b1, init_oe);
    chk("cfg_error", 1'b1, cfg_error);
    chk("done_err", 1'b1, done_oe);
  endtask

  task automatic t_tap;
    restart(3'h5);
    load(1'b1, 1'b0);
    clock_manager_locked = 1'b0;
    lock_wait_phase = 3'h2;
    repeat (6) tick();
    chk("lock_pause", 1'b1, done_oe);
    clock_manager_locked = 1'b1;
    step(4);
    startup(1'b0);
    rb(5'h05, wd(5), 1'b1);
    user_state = 32'h13579BDF;
    user_capture = 1'b1;
    step(1);
    user_capture = 1'b0;
    user_state = 32'h0;
    step(2);
    rb(5'h10, 32'h13579BDF, 1'b1);
    clk_en = 1'b0;
    user_gts = 1'b1;
    user_gsr = 1'b1;
    step(4);
    chk("gts_frozen", 1'b0, global_output_tristate);
    clk_en = 1'b1;
    step(4);
    chk("user_gts", 1'b1, global_output_tristate);
    chk("user_gsr", 1'b1, global_set_reset);
  endtask

  initial begin
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    step(2);
    chk("gsr_rst", 1'b1, global_set_reset);
    t_serial();
    t_crc();
    t_tap();
    final_report();
  end

  // the run needs about 170 us; allow several times that
  initial begin
    #1500000;
    err_count++;
    final_report();
  end
endmodule
